//--- core/wdrc_dog_timer.sv
// Watchdog time-out counter, counting synchronised oscillator ticks.
// Assumes tick is a one-pclk pulse per oscillator cycle, already synchronised.
`timescale 1ns/1ns
module wdrc_dog_timer
  import wdrc_pkg::*;
(
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic tick, // One pulse per oscillator cycle
  input wire logic restart, // Restart counter from zero
  input wire logic run, // Watchdog enabled
  input wire logic [3:0] prescale, // Time-out select
  output logic expire_q // One-cycle time-out pulse
);

  logic [20:0] cnt_q;
  logic [20:0] last;
  logic at_end;

  // A shorter prescale can leave the count past its end; that expires on the next tick
  assign last = wdrc_limit(prescale) - 21'h000001;
  assign at_end = cnt_q >= last;

  // Counter advances only on oscillator ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (restart || !run) begin
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= at_end ? '0 : cnt_q + 21'h000001;
    end
  end

  // Time-out pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expire_q <= 1'b0;
    end else begin
      expire_q <= run && !restart && tick && at_end;
    end
  end

  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_count_tick_only: assert property (!tick && !restart && run |=> $stable(cnt_q))
    else $error("count moved without an oscillator tick");
  a_restart_zero: assert property (restart |=> cnt_q == 21'h000000)
    else $error("restart did not clear the count");
  a_expire_count: assert property ($rose(expire_q) |-> $past(cnt_q) >=
      $past(wdrc_limit(prescale)) - 21'h000001)
    else $error("time-out before the selected count");
  a_longest_reserved: assert property (prescale > 4'h9 |-> last == 21'h0fffff)
    else $error("reserved prescale not at longest time-out");

endmodule

//--- core/wdrc_pkg.sv
// Package for the watchdog with reset-cause flags: register map, field
// layouts, reset values, counts and shared decode functions.
// Assumes one system clock (pclk) and an APB register port.
package wdrc_pkg;

  // Register byte addresses on the APB port
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CAUSE = 8'h04;

  // Watchdog control register, bit 7 down to bit 0
  typedef struct packed {
    logic irq_flag;
    logic irq_en;
    logic pre_hi;
    logic chg_en;
    logic rst_en;
    logic [2:0] pre_lo;
  } wdrc_ctrl_t;

  // Reset-cause register, bit 7 down to bit 0
  typedef struct packed {
    logic [3:0] unused;
    logic dog;
    logic brownout;
    logic pin;
    logic poweron;
  } wdrc_cause_t;

  localparam wdrc_ctrl_t CTRL_RST = wdrc_ctrl_t'(8'h00);
  localparam wdrc_cause_t CAUSE_RST = wdrc_cause_t'(8'h01);

  // Unlock window: change-enable holds for four pclk cycles
  localparam int UNLOCK_CYCLES = 4;
  localparam logic [2:0] UNLOCK_LAST = 3'(UNLOCK_CYCLES - 1);

  // Time-out counts in oscillator cycles: 2048 doubled per prescale code
  localparam logic [20:0] BASE_COUNT = 21'h000800;
  localparam logic [3:0] PRE_MAX = 4'h9;

  typedef enum {WDRC_STOP, WDRC_IRQ, WDRC_RST, WDRC_BOTH} wdrc_mode_t;

  // Reserved prescale codes run at the longest time-out
  function automatic logic [20:0] wdrc_limit(input logic [3:0] code);
    logic [3:0] c;
    c = (code > PRE_MAX) ? PRE_MAX : code;
    return BASE_COUNT << c;
  endfunction

  function automatic wdrc_mode_t wdrc_mode(input logic ie, input logic re);
    wdrc_mode_t m;
    m = re ? (ie ? WDRC_BOTH : WDRC_RST) : (ie ? WDRC_IRQ : WDRC_STOP);
    return m;
  endfunction

  function automatic logic wdrc_hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

endpackage

//--- core/wdrc_top.sv
// Watchdog timer with reset-cause status register, APB slave.
// Assumes presetn is the power-on reset of this always-on logic; other
// reset sources arrive as pins and the block drives the system reset pulse.
`timescale 1ns/1ns
module wdrc_top
  import wdrc_pkg::*;
(
  input wire logic pclk, // System clock, 10 MHz
  input wire logic presetn, // Power-on reset, async, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic osc_128k, // Watchdog oscillator, asynchronous
  input wire logic pin_reset, // External reset pin event, high active
  input wire logic brownout, // Brown-out detector event, high active
  input wire logic dog_always_on_fuse, // Always-on fuse programmed
  input wire logic restart, // Restart instruction, one-cycle pulse
  input wire logic irq_vector_ack, // Interrupt vector taken, one-cycle pulse
  output logic dog_irq, // Watchdog interrupt request, level
  output logic sys_reset // System reset pulse, one pclk cycle
);

  // Synchroniser stages: {fuse, brownout, pin, oscillator}
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [2:0] hist_q;
  logic [2:0] rise;
  logic tick;
  logic pin_evt;
  logic bo_evt;
  logic fuse;

  // Bus decode
  logic wr;
  logic setup;
  logic ctrl_wr;
  logic cause_wr;
  logic mapped;
  wdrc_ctrl_t w;

  // Control state
  logic irq_en_q;
  logic rst_en_q;
  logic [3:0] pre_q;
  logic chg_en_q;
  logic [2:0] win_q;
  logic irq_flag_q;
  wdrc_cause_t cause_q;
  logic sys_reset_q;
  logic [31:0] prdata_q;
  logic pslverr_q;

  // Derived
  logic irq_en_eff;
  logic rst_en_eff;
  wdrc_mode_t mode;
  logic expire;
  logic irq_set;
  logic dog_rst;
  logic sys_any;
  logic unlock;
  logic win_wr;
  wdrc_ctrl_t ctrl_view;

  // Two flops before any logic; only sync2 is read downstream
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {dog_always_on_fuse, brownout, pin_reset, osc_128k};
      sync2_q <= sync1_q;
    end
  end

  // Edge history for oscillator and reset events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_q <= 3'h0;
    end else begin
      hist_q <= sync2_q[2:0];
    end
  end

  assign rise = sync2_q[2:0] & ~hist_q;
  assign tick = rise[0];
  assign pin_evt = rise[1];
  assign bo_evt = rise[2];
  assign fuse = sync2_q[3];

  // APB decode; zero wait states
  assign wr = psel && penable && pwrite;
  assign setup = psel && !penable;
  assign ctrl_wr = wr && wdrc_hit(paddr, ADDR_CTRL);
  assign cause_wr = wr && wdrc_hit(paddr, ADDR_CAUSE);
  assign mapped = wdrc_hit(paddr, ADDR_CTRL) || wdrc_hit(paddr, ADDR_CAUSE);
  assign w = wdrc_ctrl_t'(pwdata[7:0]);

  // Effective enables: fuse overrides both stored bits, watchdog cause flag only the reset enable
  assign irq_en_eff = irq_en_q && !fuse;
  assign rst_en_eff = rst_en_q || fuse || cause_q.dog;
  assign mode = wdrc_mode(irq_en_eff, rst_en_eff);

  // Expiry action; in combined mode a pending flag means the interrupt was
  // never serviced, so the next expiry resets
  assign irq_set = expire && (mode == WDRC_IRQ ||
      (mode == WDRC_BOTH && !irq_flag_q));
  assign dog_rst = expire && (mode == WDRC_RST ||
      (mode == WDRC_BOTH && irq_flag_q));
  assign sys_any = sys_reset_q || pin_evt || bo_evt;

  // Unlock needs change-enable and reset-enable in one write
  assign unlock = ctrl_wr && w.chg_en && w.rst_en;
  assign win_wr = ctrl_wr && chg_en_q && !w.chg_en;

  // Time-out counter
  wdrc_dog_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .restart(restart || sys_any),
    .run(mode != WDRC_STOP),
    .prescale(pre_q),
    .expire_q(expire)
  );

  // Unlock window: opens on the unlock write, closes after four cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_en_q <= 1'b0;
      win_q <= 3'h0;
    end else if (sys_any || win_wr) begin
      chg_en_q <= 1'b0;
      win_q <= 3'h0;
    end else if (unlock) begin
      chg_en_q <= 1'b1;
      win_q <= UNLOCK_LAST;
    end else if (chg_en_q) begin
      chg_en_q <= win_q != 3'h0;
      win_q <= win_q - 3'h1;
    end
  end

  // Reset enable and prescale; outside the window a write can only set the reset enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_en_q <= CTRL_RST.rst_en;
      pre_q <= {CTRL_RST.pre_hi, CTRL_RST.pre_lo};
    end else begin
      if (sys_any) begin
        rst_en_q <= CTRL_RST.rst_en;
        pre_q <= {CTRL_RST.pre_hi, CTRL_RST.pre_lo};
      end else if (win_wr) begin
        rst_en_q <= w.rst_en;
        pre_q <= {w.pre_hi, w.pre_lo};
      end else if (ctrl_wr) begin
        rst_en_q <= rst_en_q || w.rst_en;
      end
      // Overrides last so they win over any write
      if (fuse || cause_q.dog || dog_rst) begin
        rst_en_q <= 1'b1;
      end
    end
  end

  // Interrupt enable; vector ack in combined mode falls back to reset mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_q <= CTRL_RST.irq_en;
    end else if (sys_any || fuse) begin
      irq_en_q <= 1'b0;
    end else if (irq_vector_ack && rst_en_eff) begin
      irq_en_q <= 1'b0;
    end else if (ctrl_wr) begin
      irq_en_q <= w.irq_en;
    end
  end

  // Interrupt flag: set wins over ack and write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flag_q <= CTRL_RST.irq_flag;
    end else if (irq_set) begin
      irq_flag_q <= 1'b1;
    end else if (sys_any || irq_vector_ack || (ctrl_wr && w.irq_flag)) begin
      irq_flag_q <= 1'b0;
    end
  end

  // Reset cause flags survive every reset but power-on; a set wins
  // over a write of zero in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_q <= CAUSE_RST;
    end else begin
      cause_q.unused <= 4'h0;
      cause_q.dog <= (cause_q.dog && !(cause_wr && !pwdata[3])) || dog_rst;
      cause_q.brownout <= (cause_q.brownout && !(cause_wr && !pwdata[2])) ||
          bo_evt;
      cause_q.pin <= (cause_q.pin && !(cause_wr && !pwdata[1])) || pin_evt;
      cause_q.poweron <= cause_q.poweron && !(cause_wr && !pwdata[0]);
    end
  end

  // System reset pulse, one pclk cycle per watchdog reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_reset_q <= 1'b0;
    end else begin
      sys_reset_q <= dog_rst;
    end
  end

  // Read view shows effective enables, not the stored bits
  always_comb begin
    ctrl_view = '0;
    ctrl_view.irq_flag = irq_flag_q;
    ctrl_view.irq_en = irq_en_eff;
    ctrl_view.pre_hi = pre_q[3];
    ctrl_view.chg_en = chg_en_q;
    ctrl_view.rst_en = rst_en_eff;
    ctrl_view.pre_lo = pre_q[2:0];
  end

  // Read data and error are captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pslverr_q <= !mapped;
      if (wdrc_hit(paddr, ADDR_CTRL) && !pwrite) begin
        prdata_q <= {24'h000000, ctrl_view};
      end else if (wdrc_hit(paddr, ADDR_CAUSE) && !pwrite) begin
        prdata_q <= {24'h000000, 4'h0, cause_q[3:0]};
      end else begin
        prdata_q <= 32'h00000000;
      end
    end
  end

  assign prdata = prdata_q;
  assign pslverr = pslverr_q && psel && penable;
  assign pready = 1'b1;
  assign dog_irq = irq_flag_q && irq_en_eff; // Level, wakes from sleep
  assign sys_reset = sys_reset_q;

  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_cause_upper_zero: assert property (cause_q.unused == 4'h0 and
      (psel && penable && !pwrite && wdrc_hit(paddr, ADDR_CAUSE) |-> prdata[7:4] == 4'h0))
    else $error("reserved cause bits not zero");
  a_dog_cause_set: assert property (dog_rst |=> cause_q.dog && sys_reset)
    else $error("watchdog reset did not set its cause flag");
  a_brownout_cause: assert property ($rose(sync2_q[2]) |=> cause_q.brownout)
    else $error("brown-out not recorded");
  a_pin_cause: assert property ($rose(sync2_q[1]) |=> cause_q.pin)
    else $error("pin reset not recorded");
  a_poweron_clear: assert property ($fell(cause_q.poweron) |->
      $past(cause_wr) && !$past(pwdata[0]))
    else $error("power-on flag cleared without software write");
  a_irq_mode: assert property (expire && mode == WDRC_IRQ |=>
      dog_irq && !sys_reset)
    else $error("interrupt mode expiry gave no interrupt");
  a_reset_mode: assert property (expire && mode == WDRC_RST |=>
      sys_reset ##1 !sys_reset)
    else $error("reset mode expiry gave no one-cycle reset");
  a_combined_first: assert property (expire && mode == WDRC_BOTH && !irq_flag_q
      |=> irq_flag_q && !sys_reset)
    else $error("combined mode first expiry wrong");
  a_fuse_force: assert property (fuse |=> rst_en_q && !irq_en_q)
    else $error("fuse did not force reset mode");
  a_guarded_fields: assert property (ctrl_wr && !chg_en_q && !sys_any &&
      !fuse && !cause_q.dog |=> $stable(pre_q) && (rst_en_q || !$past(rst_en_q)))
    else $error("guarded field changed outside unlock window");
  a_window_write: assert property (win_wr && !sys_any && !fuse && !cause_q.dog &&
      !dog_rst |=> pre_q == $past({w.pre_hi, w.pre_lo}) && rst_en_q == $past(w.rst_en))
    else $error("window write not honoured");
  a_cause_forces_en: assert property (cause_q.dog |-> rst_en_eff &&
      ctrl_view.rst_en)
    else $error("cause flag did not force reset enable");
  a_window_four: assert property (unlock && !sys_any |=>
      (chg_en_q && !ctrl_wr && !sys_any)[*4] ##1 !chg_en_q or
      (chg_en_q ##[0:3] (ctrl_wr || sys_any)))
    else $error("change-enable window not four cycles");
  a_vector_ack: assert property (irq_vector_ack && !irq_set && mode == WDRC_BOTH
      && !fuse |=> !irq_flag_q && !irq_en_q)
    else $error("vector ack did not return to reset mode");

  c_irq_expiry: cover property (expire && mode == WDRC_IRQ);
  c_combined_reset: cover property (irq_vector_ack && mode == WDRC_BOTH ##1 mode == WDRC_RST);
  c_unlock_change: cover property (unlock ##[1:4] win_wr);
  c_cause_clear: cover property (cause_wr && pwdata[3:0] == 4'h0);

endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the watchdog with its reset-cause register.
// Assumes wdrc_top answers APB with no wait state and a fast bench oscillator.
`timescale 1ns/1ns
module tb_top;
  import wdrc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, dog_irq, sys_reset;
  logic osc_128k = 1'b0, pin_reset = 1'b0, brownout = 1'b0, fuse = 1'b0;
  logic restart = 1'b0, irq_vector_ack = 1'b0, osc_run = 1'b0;
  logic [2:0] ocnt = 3'h0;
  logic [3:0] pre;
  logic [9:0] expq[$];
  logic [9:0] note;
  int n_errors = 0;
  int checked = 0;
  int n_rst = 0;
  int cyc;

  always #50 pclk = ~pclk;

  // Oscillator at one eighth of pclk, so the synchroniser always sees each edge
  always @(posedge pclk) begin
    if (osc_run) begin
      ocnt <= ocnt + 3'h1;
      osc_128k <= ocnt[2];
    end
  end

  wdrc_top i_wdrc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_128k(osc_128k), .pin_reset(pin_reset), .brownout(brownout),
    .dog_always_on_fuse(fuse), .restart(restart), .irq_vector_ack(irq_vector_ack),
    .dog_irq(dog_irq), .sys_reset(sys_reset));

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("mismatches %0d comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One APB transfer; the request stays up so a following one can run back to back
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     input logic [7:0] exp, input logic err);
    int n;
    n = 0;
    expq.push_back({wr, err, exp});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'($urandom), d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20) begin
      n_errors++;
      test_done();
    end
  endtask

  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 8'h00, 1'b0);
    idle();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic err = 1'b0);
    bus(1'b0, a, 8'h00, exp, err);
    idle();
  endtask

  // Timed change sequence: opening write then the new value at once
  task automatic unlock(input logic [7:0] d);
    bus(1'b1, ADDR_CTRL, 8'h18, 8'h00, 1'b0);
    bus(1'b1, ADDR_CTRL, d, 8'h00, 1'b0);
    idle();
  endtask

  task automatic pulse(input logic ack);
    if (ack) irq_vector_ack <= 1'b1;
    else restart <= 1'b1;
    @(posedge pclk);
    irq_vector_ack <= 1'b0;
    restart <= 1'b0;
  endtask

  task automatic event_pin(input logic bo);
    if (bo) brownout <= 1'b1;
    else pin_reset <= 1'b1;
    repeat (6) @(posedge pclk);
    brownout <= 1'b0;
    pin_reset <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask

  // Sampled on the falling edge so design updates at the rising edge have landed
  task automatic wait_hi(input logic rst, output int c);
    c = 0;
    while ((rst ? sys_reset : dog_irq) !== 1'b1 && c < 40000) begin
      @(negedge pclk);
      c++;
    end
    if (c == 40000) begin
      n_errors++;
      test_done();
    end
    @(posedge pclk);
  endtask

  // Checker side: takes the oldest note whenever an access completes
  always @(posedge pclk) begin
    if (sys_reset === 1'b1) n_rst++;
    if (psel && penable && pready === 1'b1) begin
      if (expq.size() == 0) begin
        n_errors++;
      end else begin
        note = expq.pop_front();
        chk("pslverr", {7'h0, pslverr}, {7'h0, note[8]});
        if (!note[9]) begin
          chk("prdata", prdata[7:0], note[7:0]);
          chk("prdata_hi", {7'h0, |prdata[31:8]}, 8'h00);
        end
      end
    end
  end

  initial begin
    repeat (100000) @(posedge pclk);
    n_errors++;
    test_done();
  end

  initial begin
    void'($urandom(32'h723c0674));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_CAUSE, 8'h01);
    rd(ADDR_CTRL, 8'h00);
    rd(8'h08, 8'h00, 1'b1);
    event_pin(1'b0);
    rd(ADDR_CAUSE, 8'h03);
    event_pin(1'b1);
    rd(ADDR_CAUSE, 8'h07);
    wr(ADDR_CAUSE, 8'h0d);
    rd(ADDR_CAUSE, 8'h05);
    wr(ADDR_CAUSE, 8'hf0);
    rd(ADDR_CAUSE, 8'h00);
    // Guarded fields ignore plain writes; setting the reset enable is free
    wr(ADDR_CTRL, 8'h08);
    wr(ADDR_CTRL, 8'h05);
    rd(ADDR_CTRL, 8'h08);
    bus(1'b1, ADDR_CTRL, 8'h18, 8'h00, 1'b0);
    rd(ADDR_CTRL, 8'h18);
    repeat (4) @(posedge pclk);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CTRL, 8'h08);
    pre = 4'($urandom_range(9, 0));
    unlock({2'b00, pre[3], 2'b01, pre[2:0]});
    rd(ADDR_CTRL, {2'b00, pre[3], 2'b01, pre[2:0]});
    // Reserved code is stored as written and times out at the longest count
    unlock(8'h2f);
    rd(ADDR_CTRL, 8'h2f);
    unlock(8'h00);
    rd(ADDR_CTRL, 8'h00);
    // Interrupt mode, shortest time-out, with a restart half way
    wr(ADDR_CTRL, 8'h40);
    osc_run <= 1'b1;
    pulse(1'b0);
    repeat (8000) @(posedge pclk);
    chk("irq_early", {7'h0, dog_irq}, 8'h00);
    pulse(1'b0);
    wait_hi(1'b0, cyc);
    chk("irq_time", {7'h0, cyc >= 16368 && cyc <= 16416}, 8'h01);
    rd(ADDR_CTRL, 8'hc0);
    wr(ADDR_CTRL, 8'hc0);
    rd(ADDR_CTRL, 8'h40);
    chk("irq_no_reset", n_rst[7:0], 8'h00);
    // Combined mode: interrupt, vector taken, then reset on the next expiry
    wr(ADDR_CTRL, 8'h48);
    pulse(1'b0);
    wait_hi(1'b0, cyc);
    chk("both_irq_time", {7'h0, cyc >= 16368 && cyc <= 16416}, 8'h01);
    chk("both_no_reset", n_rst[7:0], 8'h00);
    pulse(1'b1);
    rd(ADDR_CTRL, 8'h08);
    wait_hi(1'b1, cyc);
    osc_run <= 1'b0;
    chk("reset_time", {7'h0, cyc >= 16300 && cyc <= 16416}, 8'h01);
    repeat (3) @(posedge pclk);
    chk("reset_count", n_rst[7:0], 8'h01);
    rd(ADDR_CAUSE, 8'h08);
    unlock(8'h00);
    rd(ADDR_CTRL, 8'h08);
    // Stored enable was forced while the cause flag stood; it needs a change write
    wr(ADDR_CAUSE, 8'h00);
    rd(ADDR_CTRL, 8'h08);
    unlock(8'h00);
    rd(ADDR_CTRL, 8'h00);
    // Fuse forces reset mode whatever software writes
    fuse <= 1'b1;
    repeat (4) @(posedge pclk);
    wr(ADDR_CTRL, 8'h40);
    rd(ADDR_CTRL, 8'h08);
    unlock(8'h40);
    rd(ADDR_CTRL, 8'h08);
    fuse <= 1'b0;
    repeat (4) @(posedge pclk);
    // The fuse rewrote the stored bits, so they stay in reset mode after it drops
    rd(ADDR_CTRL, 8'h08);
    test_done();
  end
endmodule
